/* modulo_timer_pkg.sv */
// Package with register map, field layout and reset values of the modulo timer
package modulo_timer_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h4;
  localparam logic [3:0] OFS_COUNTER_VALUE  = 4'h8;
  localparam logic [3:0] OFS_MODULO_VALUE   = 4'hc;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_WRAP_FLAG     = 7;
  localparam int BIT_WRAP_IRQ_EN   = 6;
  localparam int BIT_COUNT_CLEAR   = 5;
  localparam int BIT_COUNTER_HALT  = 4;
  localparam int POS_SOURCE_SELECT = 4;
  localparam int POS_PRESCALE      = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [7:0] RST_MODULO   = 8'h00;
  localparam logic [1:0] RST_SOURCE   = 2'h0;
  localparam logic [3:0] RST_PRESCALE = 4'h0;
  localparam logic [7:0] RST_DIVIDER  = 8'h00;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_BUS_CLOCK  = 2'h0,
    SRC_FIXED_FREQ = 2'h1,
    SRC_PIN_FALL   = 2'h2,
    SRC_PIN_RISE   = 2'h3
  } source_t;

  localparam logic [3:0] PRESCALE_MAX = 4'h8;

  typedef struct packed {
    logic [1:0] source_select;
    logic [3:0] prescale_select;
  } clock_cfg_t;

  typedef struct packed {
    logic       halt;
    logic       irq_enable;
  } control_t;

endpackage

/* modulo_timer_tick.sv */
// Source selection, pin edge detection and power-of-two prescaler
`timescale 1ns/1ps
module modulo_timer_tick (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire modulo_timer_pkg::clock_cfg_t cfg,
  input  wire logic                         fixed_freq_clock,
  input  wire logic                         ext_count_pin,
  output logic                              tick
);

  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] pin_sync_ff;
  logic [1:0] fix_sync_ff;
  logic       pin_last_ff;
  logic       fix_last_ff;
  logic [7:0] divider_ff;
  logic       src_en;
  logic       pin_rise;
  logic       pin_fall;
  logic       fix_rise;
  logic [3:0] ps;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync_ff <= 2'h0;
      fix_sync_ff <= 2'h0;
      pin_last_ff <= 1'b0;
      fix_last_ff <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[0], ext_count_pin};
      fix_sync_ff <= {fix_sync_ff[0], fixed_freq_clock};
      pin_last_ff <= pin_sync_ff[1];
      fix_last_ff <= fix_sync_ff[1];
    end
  end

  assign pin_rise = pin_sync_ff[1] & ~pin_last_ff;
  assign pin_fall = ~pin_sync_ff[1] & pin_last_ff;
  assign fix_rise = fix_sync_ff[1] & ~fix_last_ff;

  // ---------------------------------------------------------------------------
  // Source selector
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (cfg.source_select)
      modulo_timer_pkg::SRC_BUS_CLOCK:  src_en = 1'b1;
      modulo_timer_pkg::SRC_FIXED_FREQ: src_en = fix_rise;
      modulo_timer_pkg::SRC_PIN_FALL:   src_en = pin_fall;
      modulo_timer_pkg::SRC_PIN_RISE:   src_en = pin_rise;
      default:                          src_en = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------------
  assign ps = (cfg.prescale_select > modulo_timer_pkg::PRESCALE_MAX) ?
              modulo_timer_pkg::PRESCALE_MAX : cfg.prescale_select;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divider_ff <= modulo_timer_pkg::RST_DIVIDER;
    end else if (src_en) begin
      divider_ff <= divider_ff + 8'h01;
    end
  end

  // Tick when all low divider bits below the tap are ones
  always_comb begin
    logic [8:0] mask;
    mask = (9'h001 << ps) - 9'h001;
    tick = src_en & (({1'b0, divider_ff} & mask) == mask);
  end

endmodule

/* modulo_timer.sv */
// Modulo timer top: Wishbone register file, counter and wrap flag
//
// Operation
// - 8-bit up-counter with modulo, selector, prescaler
// - Stopped, free-running, modulo; stopped after reset
// - Modulo when modulo nonzero, else free-running
// - Reset halts, zeros count, modulo, source, prescale
// - Counts only while counter_halt is zero
// - Four sources: bus, fixed, pin fall/rise
// - Source change keeps count
// - Prescale divide by 1 to 256
// - Prescale change keeps count
// - Modulo accepts 01-FF, resets to zero
// - Count to modulo, then wrap to zero
// - Wrap flag set on wrap to zero
// - Modulo write while running zeros count, clears flag
// - Flag cleared by status read then zero write
// - Overflow between read and write cancels clear
// - count_clear or modulo write clears flag
// - Irq when flag and enable both set
// - Source encodings 00 bus to 11 pin rising
// - Prescale 0000-1000, others divide by 256
// - count_clear write-only, zeros count, reads zero
// - counter_value read-only live count
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module modulo_timer (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        FIXED_FREQ_CLOCK,
  input  wire logic        EXT_COUNT_PIN,
  output logic             WRAP_IRQ
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  modulo_timer_pkg::clock_cfg_t cfg_ff;
  modulo_timer_pkg::control_t   ctl_ff;
  logic [7:0]                   count_ff;
  logic [7:0]                   modulo_ff;
  logic                         wrap_flag_ff;
  logic                         clear_armed_ff;
  logic                         ack_ff;
  logic [31:0]                  rdata_ff;
  logic                         irq_ff;
  logic                         tick;
  logic                         wrap;
  logic                         req;
  logic                         wr;
  logic                         rd;
  logic                         wr_sc;
  logic                         wr_clk;
  logic                         wr_mod;
  logic                         rd_sc;
  logic                         count_clear;
  logic [7:0]                   sc_read;

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  assign req    = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wr     = req & WB_WE_I & WB_SEL_I[0];
  assign rd     = req & ~WB_WE_I;
  assign wr_sc  = wr & hit(WB_ADR_I, modulo_timer_pkg::OFS_STATUS_CONTROL);
  assign wr_clk = wr & hit(WB_ADR_I, modulo_timer_pkg::OFS_CLOCK_CONFIG);
  assign wr_mod = wr & hit(WB_ADR_I, modulo_timer_pkg::OFS_MODULO_VALUE);
  assign rd_sc  = rd & hit(WB_ADR_I, modulo_timer_pkg::OFS_STATUS_CONTROL);
  assign count_clear = wr_sc & WB_DAT_I[modulo_timer_pkg::BIT_COUNT_CLEAR];

  assign sc_read = {wrap_flag_ff, ctl_ff.irq_enable, 1'b0, ctl_ff.halt, 4'h0};

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (rd) begin
        unique case (WB_ADR_I)
          modulo_timer_pkg::OFS_STATUS_CONTROL: rdata_ff <= {24'h000000, sc_read};
          modulo_timer_pkg::OFS_CLOCK_CONFIG:   rdata_ff <= {26'h0, cfg_ff};
          modulo_timer_pkg::OFS_COUNTER_VALUE:  rdata_ff <= {24'h000000, count_ff};
          modulo_timer_pkg::OFS_MODULO_VALUE:   rdata_ff <= {24'h000000, modulo_ff};
          default:                              rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_ff.halt       <= 1'b1;
      ctl_ff.irq_enable <= 1'b0;
    end else if (wr_sc) begin
      ctl_ff.halt       <= WB_DAT_I[modulo_timer_pkg::BIT_COUNTER_HALT];
      ctl_ff.irq_enable <= WB_DAT_I[modulo_timer_pkg::BIT_WRAP_IRQ_EN];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_ff.source_select   <= modulo_timer_pkg::RST_SOURCE;
      cfg_ff.prescale_select <= modulo_timer_pkg::RST_PRESCALE;
    end else if (wr_clk) begin
      cfg_ff <= WB_DAT_I[5:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      modulo_ff <= modulo_timer_pkg::RST_MODULO;
    end else if (wr_mod) begin
      modulo_ff <= WB_DAT_I[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Clock source and prescaler
  // ---------------------------------------------------------------------------
  modulo_timer_tick u_tick (
    .clk              (SYS_CLK),
    .rst_b            (RST_B),
    .cfg              (cfg_ff),
    .fixed_freq_clock (FIXED_FREQ_CLOCK),
    .ext_count_pin    (EXT_COUNT_PIN),
    .tick             (tick)
  );

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // Zero modulo behaves as FF: free-running wrap
  assign wrap = tick & ~ctl_ff.halt &
                (count_ff == ((modulo_ff == 8'h00) ? 8'hff : modulo_ff));

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      count_ff <= modulo_timer_pkg::RST_COUNT;
    end else if (count_clear || wr_mod) begin
      count_ff <= 8'h00;
    end else if (wrap) begin
      count_ff <= 8'h00;
    end else if (tick && !ctl_ff.halt) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Wrap flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clear_armed_ff <= 1'b0;
    end else if (wrap) begin
      clear_armed_ff <= 1'b0;
    end else if (rd_sc && wrap_flag_ff) begin
      clear_armed_ff <= 1'b1;
    end else if (wr_sc) begin
      clear_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wrap_flag_ff <= 1'b0;
    end else if (wrap) begin
      wrap_flag_ff <= 1'b1;
    end else if (count_clear || wr_mod) begin
      wrap_flag_ff <= 1'b0;
    end else if (wr_sc && clear_armed_ff &&
                 !WB_DAT_I[modulo_timer_pkg::BIT_WRAP_FLAG]) begin
      wrap_flag_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= wrap_flag_ff & ctl_ff.irq_enable;
    end
  end

  assign WRAP_IRQ = irq_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_reset_halt;
    @(posedge SYS_CLK) $rose(RST_B) |-> ctl_ff.halt && count_ff == 8'h00;
  endproperty
  a_reset_halt: assert property (p_reset_halt) else $error("not halted after reset");

  property p_halt_hold;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ctl_ff.halt && !wr_mod && !count_clear |=> $stable(count_ff);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("count moved while halted");

  property p_step;
    @(posedge SYS_CLK) disable iff (!RST_B)
      tick && !ctl_ff.halt && !wrap && !wr_mod && !count_clear
      |=> count_ff == $past(count_ff) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  property p_wrap_zero;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wrap |=> count_ff == 8'h00 && wrap_flag_ff;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap failed");

  property p_free_wrap;
    @(posedge SYS_CLK) disable iff (!RST_B)
      modulo_ff == 8'h00 && count_ff == 8'hff && tick && !ctl_ff.halt |-> wrap;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("no free wrap at ff");

  property p_mod_write;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wr_mod |=> count_ff == 8'h00 && wrap_flag_ff == $past(wrap);
  endproperty
  a_mod_write: assert property (p_mod_write) else $error("modulo write ignored");

  property p_clear_needs_read;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wrap_flag_ff && !clear_armed_ff && !wr_mod && !count_clear |=> wrap_flag_ff;
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag dropped");

  property p_irq;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wrap_flag_ff && ctl_ff.irq_enable |=> WRAP_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_ack_one;
    @(posedge SYS_CLK) disable iff (!RST_B)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");

  property p_ack_after_req;
    @(posedge SYS_CLK) disable iff (!RST_B)
      req |=> WB_ACK_O;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("ack late");

  property p_unmapped;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rd && WB_ADR_I[1:0] != 2'h0 |=> WB_DAT_O == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_read_count;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rd && WB_ADR_I == modulo_timer_pkg::OFS_COUNTER_VALUE |=>
      WB_DAT_O == {24'h000000, $past(count_ff)};
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");

  property p_mod_read;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rd && WB_ADR_I == modulo_timer_pkg::OFS_MODULO_VALUE |=> WB_DAT_O[7:0] == $past(modulo_ff);
  endproperty
  a_mod_read: assert property (p_mod_read) else $error("modulo read wrong");

  property p_read_sc;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rd_sc |=> !WB_DAT_O[modulo_timer_pkg::BIT_COUNT_CLEAR] &&
                WB_DAT_O[modulo_timer_pkg::BIT_WRAP_FLAG] == $past(wrap_flag_ff);
  endproperty
  a_read_sc: assert property (p_read_sc) else $error("status read wrong");

  property p_clear_bit;
    @(posedge SYS_CLK) disable iff (!RST_B)
      count_clear |=> count_ff == 8'h00 && wrap_flag_ff == $past(wrap);
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("count clear ignored");

  property p_halt_write;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wr_sc |=> ctl_ff.halt == $past(WB_DAT_I[modulo_timer_pkg::BIT_COUNTER_HALT]);
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("halt bit not written");

  property p_cfg_write;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wr_clk |=> cfg_ff == $past(WB_DAT_I[5:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config not written");

  property p_cfg_keep;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wr_clk && !tick |=> $stable(count_ff);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("count lost on config");

  property p_bus_tick;
    @(posedge SYS_CLK) disable iff (!RST_B)
      cfg_ff.source_select == 2'h0 && cfg_ff.prescale_select == 4'h0 |-> tick;
  endproperty
  a_bus_tick: assert property (p_bus_tick) else $error("bus clock tick missing");

  property p_mod_bound;
    @(posedge SYS_CLK) disable iff (!RST_B)
      modulo_ff != 8'h00 && count_ff <= modulo_ff |=> count_ff <= $past(modulo_ff);
  endproperty
  a_mod_bound: assert property (p_mod_bound) else $error("count passed modulo");

  property p_free_run;
    @(posedge SYS_CLK) disable iff (!RST_B)
      modulo_ff == 8'h00 && count_ff != 8'hff |-> !wrap;
  endproperty
  a_free_run: assert property (p_free_run) else $error("early free wrap");

  property p_flag_rise;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !wrap_flag_ff && !wrap |=> !wrap_flag_ff;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without wrap");

  property p_disarm;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wrap |=> !clear_armed_ff;
  endproperty
  a_disarm: assert property (p_disarm) else $error("clear still armed");

  property p_irq_off;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !wrap_flag_ff || !ctl_ff.irq_enable |=> !WRAP_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("spurious irq");

endmodule

/* modulo_timer_tb.sv */
// Self-checking testbench for the modulo timer
`timescale 1ns/1ps
module modulo_timer_tb;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        SYS_CLK          = 1'b0;
  logic        RST_B            = 1'b0;
  logic        WB_CYC_I         = 1'b0;
  logic        WB_STB_I         = 1'b0;
  logic        WB_WE_I          = 1'b0;
  logic [3:0]  WB_ADR_I         = 4'h0;
  logic [3:0]  WB_SEL_I         = 4'h0;
  logic [31:0] WB_DAT_I         = 32'h0;
  logic [31:0] WB_DAT_O;
  logic        WB_ACK_O;
  logic        FIXED_FREQ_CLOCK = 1'b0;
  logic        EXT_COUNT_PIN    = 1'b0;
  logic        WRAP_IRQ;
  int          n_mismatch       = 0;
  int          compares         = 0;
  int          cyc_n            = 0;
  int          t_ack;
  logic [2:0]  f_cnt            = 3'h0;
  logic [3:0]  p_cnt            = 4'h0;
  logic [5:0]  cfg_tab [14]     = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
                                    6'h07, 6'h08, 6'h0f, 6'h10, 6'h20, 6'h30, 6'h11};
  int          per_tab [14]     = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 8, 10, 10, 8};

  modulo_timer dut (
    .SYS_CLK          (SYS_CLK),
    .RST_B            (RST_B),
    .WB_CYC_I         (WB_CYC_I),
    .WB_STB_I         (WB_STB_I),
    .WB_WE_I          (WB_WE_I),
    .WB_ADR_I         (WB_ADR_I),
    .WB_SEL_I         (WB_SEL_I),
    .WB_DAT_I         (WB_DAT_I),
    .WB_DAT_O         (WB_DAT_O),
    .WB_ACK_O         (WB_ACK_O),
    .FIXED_FREQ_CLOCK (FIXED_FREQ_CLOCK),
    .EXT_COUNT_PIN    (EXT_COUNT_PIN),
    .WRAP_IRQ         (WRAP_IRQ)
  );

  always #50 SYS_CLK = ~SYS_CLK;

  // ---------------------------------------------------------------------------
  // Fixed clock period 8, pin period 10
  // ---------------------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    cyc_n            <= cyc_n + 1;
    f_cnt            <= f_cnt + 3'h1;
    FIXED_FREQ_CLOCK <= f_cnt[2];
    p_cnt            <= (p_cnt == 4'h9) ? 4'h0 : p_cnt + 4'h1;
    EXT_COUNT_PIN    <= (p_cnt < 4'h5);
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    @(posedge SYS_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= {24'h0, d};
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    q = WB_DAT_O[7:0];
    t_ack = cyc_n;
    if (n >= 20) n_mismatch++;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    n_mismatch++;
    summarize();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] q, a, b, c0, d;
    int         div, span, ex, n;
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    wb(0, 4'h0, 8'h00, q); check(q, 8'h10, "status reset");
    wb(0, 4'h4, 8'h00, q); check(q, 8'h00, "config reset");
    wb(0, 4'hc, 8'h00, q); check(q, 8'h00, "modulo reset");
    repeat (20) @(posedge SYS_CLK);
    wb(0, 4'h8, 8'h00, q); check(q, 8'h00, "halted count");
    wb(1, 4'h8, 8'h55, q);
    wb(0, 4'h8, 8'h00, q); check(q, 8'h00, "count ro");
    wb(0, 4'h2, 8'h00, q); check(q, 8'h00, "unmapped");
    check({7'h0, WRAP_IRQ}, 8'h00, "irq reset");
    $display("test reset done");
    wb(1, 4'hc, 8'h05, q);
    wb(0, 4'hc, 8'h00, q); check(q, 8'h05, "modulo rw");
    wb(1, 4'h0, 8'h00, q);
    for (int i = 0; i < 12; i++) begin
      wb(0, 4'h8, 8'h00, q); check({7'h0, q <= 8'h05}, 8'h01, "mod bound");
    end
    wb(0, 4'h0, 8'h00, q); check(q, 8'h80, "flag set");
    repeat (20) @(posedge SYS_CLK);
    wb(1, 4'h0, 8'h00, q);
    wb(0, 4'h0, 8'h00, q); check(q, 8'h80, "clear cancel");
    wb(1, 4'h0, 8'h10, q);
    wb(0, 4'h0, 8'h00, q);
    wb(1, 4'h0, 8'h10, q);
    wb(0, 4'h0, 8'h00, q); check(q, 8'h10, "flag cleared");
    $display("test modulo done");
    wb(1, 4'h0, 8'h40, q);
    n = 0;
    while (WRAP_IRQ !== 1'b1 && n < 100) begin
      @(posedge SYS_CLK);
      n++;
    end
    check({7'h0, WRAP_IRQ}, 8'h01, "irq");
    wb(1, 4'hc, 8'hff, q);
    wb(0, 4'h0, 8'h00, q); check(q, 8'h40, "mod wr flag");
    check({7'h0, WRAP_IRQ}, 8'h00, "irq drop");
    wb(0, 4'h8, 8'h00, q); check({7'h0, q < 8'h10}, 8'h01, "mod wr cnt");
    wb(1, 4'h0, 8'h70, q);
    wb(0, 4'h0, 8'h00, q); check(q, 8'h50, "clear bit");
    wb(0, 4'h8, 8'h00, q); check(q, 8'h00, "clear cnt");
    $display("test irq done");
    wb(1, 4'hc, 8'h00, q);
    wb(1, 4'h0, 8'h00, q);
    repeat (300) @(posedge SYS_CLK);
    wb(0, 4'h0, 8'h00, q); check(q, 8'h80, "free wrap");
    check({7'h0, WRAP_IRQ}, 8'h00, "irq off");
    wb(1, 4'h0, 8'h20, q);
    wb(0, 4'h0, 8'h00, q); check(q, 8'h00, "clear flag");
    $display("test free run done");
    for (int i = 0; i < 14; i++) begin
      div = 1 << ((cfg_tab[i][3:0] > 4'h8) ? 8 : cfg_tab[i][3:0]);
      wb(0, 4'h8, 8'h00, c0);
      wb(1, 4'h4, {2'h0, cfg_tab[i]}, q);
      wb(0, 4'h4, 8'h00, q); check(q, {2'h0, cfg_tab[i]}, "config rw");
      wb(0, 4'h8, 8'h00, a);
      d = a - c0;
      check({7'h0, d <= 8'h0c}, 8'h01, "count kept");
      span = t_ack;
      repeat (16 * div * per_tab[i]) @(posedge SYS_CLK);
      wb(0, 4'h8, 8'h00, b);
      span = t_ack - span;
      ex = span / (div * per_tab[i]);
      d = b - a;
      check({7'h0, int'(d) >= ex - 1 && int'(d) <= ex + 1}, 8'h01, "rate");
    end
    $display("test rates done");
    wb(1, 4'hc, 8'h33, q);
    RST_B <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    wb(0, 4'h4, 8'h00, q); check(q, 8'h00, "config rst2");
    wb(0, 4'hc, 8'h00, q); check(q, 8'h00, "modulo rst2");
    wb(0, 4'h0, 8'h00, q); check(q, 8'h10, "status rst2");
    wb(0, 4'h8, 8'h00, q); check(q, 8'h00, "count rst2");
    $display("test reset again done");
    summarize();
  end
endmodule
